// *** common/par_pkg.sv ***
package par_pkg;
  // Register port widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_ID_UPPER = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_ID_LOWER = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_ADVERT = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_PHY_CTRL = 5'h19;
  // Vendor code slicing, vector bit 23 is vendor code bit 1
  localparam int OUI_W = 24;
  localparam int OUI_HI_MSB = 21;
  localparam int OUI_HI_LSB = 6;
  localparam int OUI_LO_MSB = 5;
  localparam int OUI_LO_LSB = 0;
  // Second identifier register fields
  localparam int VCODE_LSB = 10;
  localparam int MODEL_MSB = 9;
  localparam int MODEL_LSB = 4;
  localparam int REV_MSB = 3;
  localparam int REV_LSB = 0;
  // Advertisement register fields
  localparam int BIT_NEXT_PAGE = 15;
  localparam int BIT_RSVD_HI = 14;
  localparam int BIT_REMOTE_FAULT = 13;
  localparam int BIT_RSVD_LO = 12;
  localparam int BIT_ASYM_PAUSE = 11;
  localparam int BIT_SYM_PAUSE = 10;
  localparam int BIT_T4 = 9;
  localparam int ABIL_MSB = 8;
  localparam int ABIL_LSB = 5;
  localparam int SEL_MSB = 4;
  localparam int SEL_LSB = 0;
  localparam logic [DATA_W-1:0] ADVERT_WR_MASK = 16'hADFF;
  localparam logic [DATA_W-1:0] ADVERT_RESET = 16'h0001;
  localparam logic [SEL_MSB:SEL_LSB] SELECTOR_FAST_ETH = 5'h01;
  // PHY control register pause status field
  localparam int PAUSE_RES_MSB = 13;
  localparam int PAUSE_RES_LSB = 12;
  // Strap capture sequence
  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } par_state_e;
endpackage

// *** hdl/par_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module par_regs
  import par_pkg::*;
#(
  parameter logic [OUI_W-1:0] VENDOR_CODE = 24'h00A5C3, // Arbitrary value
  parameter logic [5:0] MODEL_NUMBER = 6'h15, // Arbitrary value
  parameter logic [3:0] MODEL_REVISION = 4'h2 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Management register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Ability straps, fast full, fast half, slow full, slow half
  input wire logic [ABIL_MSB-ABIL_LSB:0] ability_strap,
  // Pause resolution from the negotiation logic
  input wire logic [PAUSE_RES_MSB-PAUSE_RES_LSB:0] pause_resolved,
  // Ability word toward the negotiation logic
  output logic [DATA_W-1:0] adv_word_q,
  output logic ready_q
);

  // Fixed identifier words, top two vendor code bits never stored
  logic [DATA_W-1:0] id_upper_word;
  logic [DATA_W-1:0] id_lower_word;
  assign id_upper_word = VENDOR_CODE[OUI_HI_MSB:OUI_HI_LSB];
  assign id_lower_word = {VENDOR_CODE[OUI_LO_MSB:OUI_LO_LSB],
                          MODEL_NUMBER,
                          MODEL_REVISION};

  // Strap capture sequence state
  par_state_e state_q;
  par_state_e state_d;

  // One load cycle after release, straps are not read under reset
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_LOAD: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // Advertisement register next value
  logic [DATA_W-1:0] adv_d;
  logic adv_wr_hit;
  assign adv_wr_hit = reg_wr && (reg_addr == ADDR_ADVERT);

  always_comb begin
    adv_d = adv_word_q;
    if (state_q == ST_LOAD) begin
      adv_d[ABIL_MSB:ABIL_LSB] = ability_strap;
    end else if (adv_wr_hit) begin
      // Masked bits 14, 12 and 9 stay 0 whatever software writes
      adv_d = reg_wdata & ADVERT_WR_MASK;
    end
    adv_d[BIT_RSVD_HI] = 1'b0;
    adv_d[BIT_RSVD_LO] = 1'b0;
    adv_d[BIT_T4] = 1'b0;
  end

  // Reset value holds selector 00001, flags clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adv_word_q <= ADVERT_RESET;
    end else begin
      adv_word_q <= adv_d;
    end
  end

  // Read mux; identifier addresses accept no write at all
  logic [DATA_W-1:0] rdata_d;
  logic rvalid_d;
  logic ready_d;

  always_comb begin
    rdata_d = reg_rdata_q;
    rvalid_d = reg_rd;
    ready_d = (state_d == ST_RUN);
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_ID_UPPER: rdata_d = id_upper_word;
        ADDR_ID_LOWER: rdata_d = id_lower_word;
        ADDR_ADVERT: rdata_d = adv_word_q;
        ADDR_PHY_CTRL: begin
          rdata_d = '0;
          rdata_d[PAUSE_RES_MSB:PAUSE_RES_LSB] = pause_resolved;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= '0;
      reg_rvalid_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      reg_rdata_q <= rdata_d;
      reg_rvalid_q <= rvalid_d;
      ready_q <= ready_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  id_upper_read_a: assert property (
    reg_rd && reg_addr == ADDR_ID_UPPER |=>
      reg_rvalid_q && reg_rdata_q == VENDOR_CODE[OUI_HI_MSB:OUI_HI_LSB])
    else $error("first identifier word wrong");

  id_lower_code_a: assert property (
    reg_rd && reg_addr == ADDR_ID_LOWER |=>
      reg_rdata_q[DATA_W-1:VCODE_LSB] == VENDOR_CODE[OUI_LO_MSB:OUI_LO_LSB])
    else $error("vendor code low bits wrong");

  model_number_a: assert property (
    reg_rd && reg_addr == ADDR_ID_LOWER |=>
      reg_rdata_q[MODEL_MSB:MODEL_LSB] == MODEL_NUMBER)
    else $error("model number field wrong");

  model_revision_a: assert property (
    reg_rd && reg_addr == ADDR_ID_LOWER |=>
      reg_rdata_q[REV_MSB:REV_LSB] == MODEL_REVISION)
    else $error("model revision field wrong");

  reserved_zero_a: assert property (
    adv_word_q[BIT_RSVD_HI] == 1'b0 && adv_word_q[BIT_RSVD_LO] == 1'b0)
    else $error("reserved advert bit set");

  t4_zero_a: assert property (
    reg_rd && reg_addr == ADDR_ADVERT |=> reg_rdata_q[BIT_T4] == 1'b0)
    else $error("T4 bit reads nonzero");

  advert_write_a: assert property (
    state_q == ST_RUN && adv_wr_hit |=>
      adv_word_q[BIT_NEXT_PAGE] == $past(reg_wdata[BIT_NEXT_PAGE]) &&
      adv_word_q[SEL_MSB:SEL_LSB] == $past(reg_wdata[SEL_MSB:SEL_LSB]))
    else $error("advert write not stored");

  pause_flags_a: assert property (
    state_q == ST_RUN && adv_wr_hit |=>
      adv_word_q[BIT_ASYM_PAUSE] == $past(reg_wdata[BIT_ASYM_PAUSE]) &&
      adv_word_q[BIT_SYM_PAUSE] == $past(reg_wdata[BIT_SYM_PAUSE]) &&
      adv_word_q[BIT_REMOTE_FAULT] == $past(reg_wdata[BIT_REMOTE_FAULT]))
    else $error("pause or fault flag not stored");

  id_write_ignored_a: assert property (
    state_q == ST_RUN && reg_wr && !reg_rd &&
    (reg_addr == ADDR_ID_UPPER || reg_addr == ADDR_ID_LOWER) |=>
      $stable(adv_word_q) && $stable(reg_rdata_q))
    else $error("identifier write had an effect");

  // Sampled reset keeps the release edge itself out of this check
  strap_load_a: assert property (
    state_q == ST_LOAD && reset_n |=>
      adv_word_q[ABIL_MSB:ABIL_LSB] == $past(ability_strap) &&
      adv_word_q[SEL_MSB:SEL_LSB] == SELECTOR_FAST_ETH && ready_q)
    else $error("strap load wrong");

  pause_status_a: assert property (
    reg_rd && reg_addr == ADDR_PHY_CTRL |=>
      reg_rdata_q[PAUSE_RES_MSB:PAUSE_RES_LSB] == $past(pause_resolved))
    else $error("pause resolution not reported");

  // Read port timing, valid is a strict one-cycle echo of the strobe
  read_valid_a: assert property (
    reg_rd |=> reg_rvalid_q)
    else $error("read valid missing");

  valid_pulse_a: assert property (
    !reg_rd |=> !reg_rvalid_q)
    else $error("read valid without a read");

  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");

  unmapped_read_a: assert property (
    reg_rd && reg_addr != ADDR_ID_UPPER && reg_addr != ADDR_ID_LOWER &&
    reg_addr != ADDR_ADVERT && reg_addr != ADDR_PHY_CTRL |=>
      reg_rdata_q == '0)
    else $error("unmapped read not zero");

  advert_read_a: assert property (
    reg_rd && reg_addr == ADDR_ADVERT |=> reg_rdata_q == $past(adv_word_q))
    else $error("advert read wrong");

  advert_hold_a: assert property (
    state_q == ST_RUN && !adv_wr_hit |=> $stable(adv_word_q))
    else $error("advert changed without a write");

  // Writable advert fields, one per rule so a failure names the field
  next_page_a: assert property (
    state_q == ST_RUN && adv_wr_hit |=>
      adv_word_q[BIT_NEXT_PAGE] == $past(reg_wdata[BIT_NEXT_PAGE]))
    else $error("next page flag not stored");

  remote_fault_a: assert property (
    state_q == ST_RUN && adv_wr_hit |=>
      adv_word_q[BIT_REMOTE_FAULT] == $past(reg_wdata[BIT_REMOTE_FAULT]))
    else $error("remote fault flag not stored");

  asym_pause_a: assert property (
    state_q == ST_RUN && adv_wr_hit |=>
      adv_word_q[BIT_ASYM_PAUSE] == $past(reg_wdata[BIT_ASYM_PAUSE]))
    else $error("asymmetric pause flag not stored");

  sym_pause_a: assert property (
    state_q == ST_RUN && adv_wr_hit |=>
      adv_word_q[BIT_SYM_PAUSE] == $past(reg_wdata[BIT_SYM_PAUSE]))
    else $error("symmetric pause flag not stored");

  ability_write_a: assert property (
    state_q == ST_RUN && adv_wr_hit |=>
      adv_word_q[ABIL_MSB:ABIL_LSB] == $past(reg_wdata[ABIL_MSB:ABIL_LSB]))
    else $error("ability flags not stored");

  selector_write_a: assert property (
    state_q == ST_RUN && adv_wr_hit |=>
      adv_word_q[SEL_MSB:SEL_LSB] == $past(reg_wdata[SEL_MSB:SEL_LSB]))
    else $error("selector not stored");

  // Bits that never hold a one
  rsvd_low_zero_a: assert property (
    adv_word_q[BIT_RSVD_LO] == 1'b0)
    else $error("reserved low advert bit set");

  t4_stored_a: assert property (
    adv_word_q[BIT_T4] == 1'b0)
    else $error("T4 advert bit set");

  rsvd_read_a: assert property (
    reg_rd && reg_addr == ADDR_ADVERT |=>
      reg_rdata_q[BIT_RSVD_HI] == 1'b0 && reg_rdata_q[BIT_RSVD_LO] == 1'b0)
    else $error("reserved advert bit reads one");

  // Flags come out of the load cycle cleared
  flags_reset_a: assert property (
    state_q == ST_LOAD && reset_n |=>
      adv_word_q[BIT_NEXT_PAGE] == 1'b0 &&
      adv_word_q[BIT_REMOTE_FAULT] == 1'b0 &&
      adv_word_q[BIT_ASYM_PAUSE] == 1'b0 &&
      adv_word_q[BIT_SYM_PAUSE] == 1'b0)
    else $error("advert flags not clear after load");

  ready_hold_a: assert property (
    ready_q |=> ready_q)
    else $error("ready dropped");

  state_legal_a: assert property (
    state_q == ST_LOAD || state_q == ST_RUN)
    else $error("illegal strap state");

  pause_other_a: assert property (
    reg_rd && reg_addr == ADDR_PHY_CTRL |=>
      reg_rdata_q[DATA_W-1:PAUSE_RES_MSB+1] == '0 &&
      reg_rdata_q[PAUSE_RES_LSB-1:0] == '0)
    else $error("control register spare bits set");

  id_lower_full_a: assert property (
    reg_rd && reg_addr == ADDR_ID_LOWER |=>
      reg_rdata_q == {VENDOR_CODE[OUI_LO_MSB:OUI_LO_LSB], MODEL_NUMBER,
                      MODEL_REVISION})
    else $error("second identifier word wrong");

  // Main scenarios
  id_read_c: cover property (
    reg_rd && reg_addr == ADDR_ID_LOWER ##1 reg_rd && reg_addr == ADDR_ID_UPPER);
  advert_rw_c: cover property (
    adv_wr_hit && state_q == ST_RUN ##1 reg_rd && reg_addr == ADDR_ADVERT);
  id_write_c: cover property (
    reg_wr && reg_addr == ADDR_ID_UPPER && state_q == ST_RUN);
  pause_read_c: cover property (
    reg_rd && reg_addr == ADDR_PHY_CTRL && pause_resolved != '0);
  strap_load_c: cover property (
    state_q == ST_LOAD && reset_n);

endmodule
`default_nettype wire

// *** verif/par_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
module par_partner
  import par_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Local ability word
  input wire logic [DATA_W-1:0] adv_word_q,
  // Resolution outcome
  output logic [1:0] pause_resolved
);
  logic [1:0] pause_q;
  logic [1:0] pause_d;
  // Stand-in resolution: a willing partner echoes our pause offer
  always_comb begin
    pause_d = {adv_word_q[10], adv_word_q[11]};
  end
  // Registered, as real negotiation logic would be
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pause_q <= 2'h0;
    end else begin
      pause_q <= pause_d;
    end
  end
  assign pause_resolved = pause_q;
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  import par_pkg::*;
  localparam logic [OUI_W-1:0] VC = 24'hF3A96C; // Arbitrary value
  localparam logic [5:0] MN = 6'h2B; // Arbitrary value
  localparam logic [3:0] MR = 4'h9; // Arbitrary value
  localparam logic [3:0] STRAP = 4'hA;
  logic clk, reset_n, reg_wr, reg_rd, ready_q, reg_rvalid_q;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata_q, adv_word_q;
  logic [1:0] pause_resolved;
  logic [15:0] pat [7] = '{16'hEFFF, 16'h8000, 16'h2000, 16'h0800,
                           16'h0400, 16'h01E0, 16'h001F};
  int error_cnt = 0;
  int samples_checked = 0;
  par_regs #(.VENDOR_CODE(VC), .MODEL_NUMBER(MN), .MODEL_REVISION(MR))
  u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .ability_strap(STRAP), .pause_resolved(pause_resolved),
    .adv_word_q(adv_word_q), .ready_q(ready_q));
  par_partner u_far (.clk(clk), .reset_n(reset_n),
    .adv_word_q(adv_word_q), .pause_resolved(pause_resolved));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One-cycle write strobe; no acknowledge exists
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read, valid must pulse for exactly one cycle
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({15'h0, reg_rvalid_q}, 16'h0001);
    chk(reg_rdata_q, exp);
    @(posedge clk);
    #1;
    chk({15'h0, reg_rvalid_q}, 16'h0000);
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    // Bounded wait for strap load
    for (int i = 0; i < 20 && ready_q !== 1'b1; i++) @(posedge clk);
    if (ready_q !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    chk(adv_word_q, {7'h00, STRAP, 5'h01});
    rdc(ADDR_ADVERT, {7'h00, STRAP, 5'h01});
    rdc(ADDR_ID_UPPER, VC[21:6]);
    rdc(ADDR_ID_LOWER, {VC[5:0], MN, MR});
    chk({10'h000, reg_rdata_q[9:4]}, {10'h000, MN});
    chk({12'h000, reg_rdata_q[3:0]}, {12'h000, MR});
    // Identifier words must ignore writes
    wr(ADDR_ID_UPPER, 16'h0000);
    wr(ADDR_ID_LOWER, 16'hFFFF);
    rdc(ADDR_ID_UPPER, VC[21:6]);
    rdc(ADDR_ID_LOWER, {VC[5:0], MN, MR});
    // Bit walk; bit 12 always written as 0 by software
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_ADVERT, pat[i]);
      chk(adv_word_q, pat[i] & 16'hADFF);
      rdc(ADDR_ADVERT, pat[i] & 16'hADFF);
    end
    chk(adv_word_q & 16'h1000, 16'h0000);
    // Pause outcome reported apart from the advert word
    wr(ADDR_ADVERT, 16'h0400);
    rdc(ADDR_PHY_CTRL, 16'h2000);
    wr(ADDR_ADVERT, 16'h0800);
    rdc(ADDR_PHY_CTRL, 16'h1000);
    // Unmapped place reads zero
    rdc(5'h1F, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
